// >>> core/tcsc_core.sv
// Timer clock selection, slave mode controller and two capture/compare channels.
// Assumes pins are asynchronous and all software strobes are one-cycle core_clk pulses.
`timescale 1ns/1ps
`default_nettype none

module tcsc_core (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] timer_input_pin,
    input wire logic [3:0] internal_trigger_input,
    input wire logic [2:0] slave_mode_select,
    input wire logic [2:0] trigger_select,
    input wire logic counter_run,
    input wire logic count_down,
    input wire logic update_generate_wr,
    input wire logic trigger_flag_clr,
    input wire tcsc_pkg::tcsc_chan_cfg_t [1:0] chan_cfg,
    input wire logic [1:0] value_wr,
    input wire tcsc_pkg::tcsc_count_t value_wr_data,
    input wire logic [1:0] value_rd,
    input wire logic [1:0] event_flag_clr,
    input wire logic [1:0] overcapture_clr,
    input wire logic [1:0] channel_event_generate,
    output logic update_generate,
    output logic trigger_flag,
    output tcsc_pkg::tcsc_count_t counter_value,
    output tcsc_pkg::tcsc_count_t [1:0] channel_value,
    output logic [1:0] channel_event_flag,
    output logic [1:0] overcapture_flag,
    output logic [1:0] channel_irq,
    output logic [1:0] compare_reference_signal,
    output logic [1:0] compare_output
);
    import tcsc_pkg::*;

    // ------------------------------------------------------------
    // Shared signals
    // ------------------------------------------------------------
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [1:0] filt;
    logic [1:0] filt_d;
    logic [1:0] filtered_edge_trigger;
    logic [1:0] capture;
    logic [3:0] itr_d;
    logic [3:0] itr_edge;
    logic trgi;

    function automatic logic [3:0] filt_len(input logic [3:0] s);
        return (s == FILT_N2) ? FILT_LEN_2 : ((s == FILT_N4) ? FILT_LEN_4 : FILT_LEN_8);
    endfunction : filt_len

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_s1 <= 2'h0;
            pin_s2 <= 2'h0;
        end else begin
            pin_s1 <= timer_input_pin;
            pin_s2 <= pin_s1;
        end
    end

    // ------------------------------------------------------------
    // Slave mode controller
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            itr_d <= 4'h0;
        end else begin
            itr_d <= internal_trigger_input;
        end
    end

    assign itr_edge = internal_trigger_input & ~itr_d;

    always_comb begin
        trgi = 1'b0;
        if (trigger_select == TS_CH1_EDGE) begin
            trgi = filtered_edge_trigger[0];
        end else if (trigger_select == TS_CH2_EDGE) begin
            trgi = filtered_edge_trigger[1];
        end else if (!trigger_select[2]) begin
            trgi = itr_edge[trigger_select[1:0]];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            update_generate <= 1'b0;
        end else begin
            update_generate <= update_generate_wr;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            trigger_flag <= 1'b0;
        end else if (slave_mode_select != SMS_DISABLED && trgi) begin
            trigger_flag <= 1'b1;
        end else if (trigger_flag_clr) begin
            trigger_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            counter_value <= CNT_ZERO;
        end else if (update_generate) begin
            counter_value <= CNT_ZERO;
        end else if (slave_mode_select == SMS_RESET && trgi) begin
            counter_value <= CNT_ZERO;
        end else if (counter_run && (slave_mode_select != SMS_EXT_CLK1 || trgi)) begin
            counter_value <= count_down ? counter_value - CNT_ONE : counter_value + CNT_ONE;
        end
    end

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_ch
        localparam int OTH = 1 - i;
        tcsc_chan_cfg_t cfg;
        logic [3:0] fcnt;
        logic [2:0] pcnt;
        logic [2:0] ptop;
        logic in_mode;
        logic src_filt;
        logic src_filt_d;
        logic ic_edge;
        logic eq;
        logic eq_d;
        logic match;
        logic evt_set;
        logic next_evt;
        logic next_ovr;
        tcsc_count_t shadow;

        assign cfg = chan_cfg[i];
        assign in_mode = cfg.channel_select != CS_OUTPUT;
        assign src_filt = (cfg.channel_select == CS_NEIGH_INPUT) ? filt[OTH] : filt[i];
        assign src_filt_d = (cfg.channel_select == CS_NEIGH_INPUT) ? filt_d[OTH] : filt_d[i];
        assign filtered_edge_trigger[i] = cfg.channel_polarity ? (filt_d[i] & ~filt[i])
                                                               : (filt[i] & ~filt_d[i]);
        assign ic_edge = cfg.channel_polarity ? (src_filt_d & ~src_filt)
                                              : (src_filt & ~src_filt_d);

        // Input filter
        always_ff @(posedge core_clk) begin
            if (rst) begin
                filt[i] <= 1'b0;
                fcnt <= 4'h0;
            end else if (cfg.input_filter_setting == FILT_OFF) begin
                filt[i] <= pin_s2[i];
                fcnt <= 4'h0;
            end else if (pin_s2[i] == filt[i]) begin
                fcnt <= 4'h0;
            end else if (fcnt == filt_len(cfg.input_filter_setting) - 4'h1) begin
                filt[i] <= pin_s2[i];
                fcnt <= 4'h0;
            end else begin
                fcnt <= fcnt + 4'h1;
            end
        end

        always_ff @(posedge core_clk) begin
            if (rst) begin
                filt_d[i] <= 1'b0;
            end else begin
                filt_d[i] <= filt[i];
            end
        end

        // Input prescaler
        assign ptop = 3'((4'h1 << cfg.input_prescale) - 4'h1);
        always_ff @(posedge core_clk) begin
            if (rst || !in_mode || !cfg.channel_enable) begin
                pcnt <= 3'h0;
            end else if (ic_edge) begin
                pcnt <= (pcnt == ptop) ? 3'h0 : pcnt + 3'h1;
            end
        end

        assign capture[i] = in_mode
            && ((cfg.channel_enable && ic_edge && pcnt == ptop) || channel_event_generate[i]);

        // Preload and shadow registers
        always_ff @(posedge core_clk) begin
            if (rst) begin
                shadow <= CNT_ZERO;
                channel_value[i] <= CNT_ZERO;
            end else if (capture[i]) begin
                shadow <= counter_value;
                channel_value[i] <= counter_value;
            end else if (!in_mode) begin
                shadow <= channel_value[i];
                if (value_wr[i]) begin
                    channel_value[i] <= value_wr_data;
                end
            end
        end

        // Compare still runs while forced
        assign eq = counter_value == shadow;
        assign match = !in_mode && eq && !eq_d;
        always_ff @(posedge core_clk) begin
            if (rst) begin
                eq_d <= 1'b0;
            end else begin
                eq_d <= eq;
            end
        end

        // Flags, set wins over clear
        assign evt_set = capture[i] || match || (!in_mode && channel_event_generate[i]);
        assign next_evt = evt_set
            || (channel_event_flag[i] && !event_flag_clr[i] && !value_rd[i]);
        assign next_ovr = (capture[i] && channel_event_flag[i])
            || (overcapture_flag[i] && !overcapture_clr[i]);

        always_ff @(posedge core_clk) begin
            if (rst) begin
                channel_event_flag[i] <= 1'b0;
                overcapture_flag[i] <= 1'b0;
                channel_irq[i] <= 1'b0;
            end else begin
                channel_event_flag[i] <= next_evt;
                overcapture_flag[i] <= next_ovr;
                channel_irq[i] <= next_evt && cfg.channel_interrupt_enable;
            end
        end

        // Forced output
        always_ff @(posedge core_clk) begin
            if (rst) begin
                compare_reference_signal[i] <= 1'b0;
            end else if (!in_mode && cfg.output_compare_mode_sel == OCM_FORCE_HIGH) begin
                compare_reference_signal[i] <= 1'b1;
            end else if (!in_mode && cfg.output_compare_mode_sel == OCM_FORCE_LOW) begin
                compare_reference_signal[i] <= 1'b0;
            end
        end

        always_ff @(posedge core_clk) begin
            if (rst) begin
                compare_output[i] <= 1'b0;
            end else begin
                compare_output[i] <= cfg.channel_enable
                    && (compare_reference_signal[i] ^ cfg.channel_polarity);
            end
        end

        // --------------------------------------------------------
        // Checks
        // --------------------------------------------------------
        sequence s_unfiltered;
            (cfg.input_filter_setting == FILT_OFF) [*4];
        endsequence
        sequence s_force_high;
            (!in_mode && cfg.output_compare_mode_sel == OCM_FORCE_HIGH
             && cfg.channel_enable && !cfg.channel_polarity) [*2];
        endsequence
        sync_delay_a: assert property (@(posedge core_clk) disable iff (rst)
            s_unfiltered |-> filt[i] == $past(timer_input_pin[i], 3))
            else $error("filtered input does not follow pin after sync delay");
        capture_val_a: assert property (@(posedge core_clk) disable iff (rst)
            capture[i] |=> channel_value[i] == $past(counter_value) && channel_event_flag[i])
            else $error("capture did not latch counter and set flag");
        overcapture_a: assert property (@(posedge core_clk) disable iff (rst)
            capture[i] && channel_event_flag[i] |=> overcapture_flag[i])
            else $error("overcapture not flagged");
        read_clear_a: assert property (@(posedge core_clk) disable iff (rst)
            value_rd[i] && !evt_set |=> !channel_event_flag[i])
            else $error("read did not clear event flag");
        force_out_a: assert property (@(posedge core_clk) disable iff (rst)
            s_force_high |=> compare_reference_signal[i] && compare_output[i])
            else $error("forced high output not seen");
    end

    // ------------------------------------------------------------
    // Counter and trigger flag checks
    // ------------------------------------------------------------
    ug_clear_a: assert property (@(posedge core_clk) disable iff (rst)
        update_generate |=> counter_value == CNT_ZERO)
        else $error("update generate did not clear counter");
    int_count_a: assert property (@(posedge core_clk) disable iff (rst)
        slave_mode_select == SMS_DISABLED && counter_run && !count_down && !update_generate
        |=> counter_value == $past(counter_value) + CNT_ONE)
        else $error("internal clock count missing");
    ext_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        slave_mode_select == SMS_EXT_CLK1 && !trgi && !update_generate
        |=> $stable(counter_value))
        else $error("external clock mode counted without edge");
    trig_flag_a: assert property (@(posedge core_clk) disable iff (rst)
        slave_mode_select != SMS_DISABLED && trgi |=> trigger_flag)
        else $error("trigger flag not set");
    reset_mode_a: assert property (@(posedge core_clk) disable iff (rst)
        slave_mode_select == SMS_RESET && trgi |=> counter_value == CNT_ZERO)
        else $error("reset mode did not clear counter");
endmodule : tcsc_core

`default_nettype wire

// >>> shared/tcsc_pkg.sv
// Constants and carrier types for the timer clock select and capture channel block.
// Assumes a single core clock; no register bus, all controls arrive as plain ports.
package tcsc_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int CNT_W = 16;
    typedef logic [CNT_W-1:0] tcsc_count_t;
    localparam tcsc_count_t CNT_ZERO = 16'h0000;
    localparam tcsc_count_t CNT_ONE = 16'h0001;

    // ------------------------------------------------------------
    // Slave mode and trigger select codes
    // ------------------------------------------------------------
    localparam logic [2:0] SMS_DISABLED = 3'h0;
    localparam logic [2:0] SMS_RESET = 3'h4;
    localparam logic [2:0] SMS_EXT_CLK1 = 3'h7;
    localparam logic [2:0] TS_CH1_EDGE = 3'h5;
    localparam logic [2:0] TS_CH2_EDGE = 3'h6;

    // ------------------------------------------------------------
    // Channel field codes
    // ------------------------------------------------------------
    localparam logic [1:0] CS_OUTPUT = 2'h0;
    localparam logic [1:0] CS_OWN_INPUT = 2'h1;
    localparam logic [1:0] CS_NEIGH_INPUT = 2'h2;
    localparam logic [3:0] FILT_OFF = 4'h0;
    localparam logic [3:0] FILT_N2 = 4'h1;
    localparam logic [3:0] FILT_N4 = 4'h2;
    localparam logic [3:0] FILT_N8 = 4'h3;
    localparam logic [3:0] FILT_LEN_2 = 4'h2;
    localparam logic [3:0] FILT_LEN_4 = 4'h4;
    localparam logic [3:0] FILT_LEN_8 = 4'h8;
    localparam logic [1:0] PS_NONE = 2'h0;
    localparam logic [2:0] OCM_FORCE_LOW = 3'h4;
    localparam logic [2:0] OCM_FORCE_HIGH = 3'h5;

    // ------------------------------------------------------------
    // Per channel configuration
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] channel_select;
        logic [3:0] input_filter_setting;
        logic channel_polarity;
        logic [1:0] input_prescale;
        logic channel_enable;
        logic channel_interrupt_enable;
        logic [2:0] output_compare_mode_sel;
    } tcsc_chan_cfg_t;

endpackage : tcsc_pkg

// >>> testbench/tcsc_pin_model.sv
// Behavioural model of the two asynchronous timer input pins.
// Assumes the bench requests pin levels at falling edges of core_clk.
`timescale 1ns/1ps
`default_nettype none

module tcsc_pin_model #(
    parameter int SKEW_NS = 7
) (
    input wire logic [1:0] pin_req,
    output logic [1:0] timer_input_pin
);
    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    // Levels move off the clock grid, as an outside signal would
    initial timer_input_pin = 2'h0;
    always @(pin_req) begin
        timer_input_pin <= #(SKEW_NS) pin_req;
    end
endmodule : tcsc_pin_model

`default_nettype wire

// >>> testbench/timer_clock_select_capture_channel_tb.sv
// Self-checking bench for the timer clock select and capture channel core.
// Assumes tcsc_pkg is compiled first; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none

module timer_clock_select_capture_channel_tb;
    import tcsc_pkg::*;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic core_clk, rst, counter_run, count_down, update_generate_wr, trigger_flag_clr;
    logic update_generate, trigger_flag;
    logic [1:0] pin_req, timer_input_pin, value_wr, value_rd, event_flag_clr, overcapture_clr;
    logic [1:0] channel_event_generate, channel_event_flag, overcapture_flag, channel_irq;
    logic [1:0] compare_reference_signal, compare_output;
    logic [2:0] slave_mode_select, trigger_select;
    logic [3:0] itr_req;
    tcsc_chan_cfg_t [1:0] chan_cfg;
    tcsc_count_t value_wr_data, counter_value, start_val;
    tcsc_count_t [1:0] channel_value;
    int num_errors = 0;
    int check_count = 0;

    tcsc_pin_model u_pins (.pin_req(pin_req), .timer_input_pin(timer_input_pin));

    tcsc_core u_dut (
        .core_clk(core_clk), .rst(rst), .timer_input_pin(timer_input_pin),
        .internal_trigger_input(itr_req), .slave_mode_select(slave_mode_select),
        .trigger_select(trigger_select), .counter_run(counter_run), .count_down(count_down),
        .update_generate_wr(update_generate_wr), .trigger_flag_clr(trigger_flag_clr),
        .chan_cfg(chan_cfg), .value_wr(value_wr), .value_wr_data(value_wr_data),
        .value_rd(value_rd), .event_flag_clr(event_flag_clr),
        .overcapture_clr(overcapture_clr), .channel_event_generate(channel_event_generate),
        .update_generate(update_generate), .trigger_flag(trigger_flag),
        .counter_value(counter_value), .channel_value(channel_value),
        .channel_event_flag(channel_event_flag), .overcapture_flag(overcapture_flag),
        .channel_irq(channel_irq), .compare_reference_signal(compare_reference_signal),
        .compare_output(compare_output)
    );

    initial begin
        core_clk = 1'h0;
        forever #20 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc

    task automatic do_reset(input int n);
        pin_req = 2'h0;
        chan_cfg = '0;
        {counter_run, count_down, update_generate_wr, trigger_flag_clr} = 4'h0;
        {value_wr, value_rd, event_flag_clr, overcapture_clr} = 8'h00;
        channel_event_generate = 2'h0;
        itr_req = 4'h0;
        value_wr_data = 16'h0000;
        slave_mode_select = SMS_DISABLED;
        trigger_select = 3'h0;
        rst = 1'h1;
        cyc(n);
        rst = 1'h0;
    endtask : do_reset

    task automatic set_ch(input int i, input logic [1:0] sel, input logic [3:0] filt,
                          input logic pol, input logic en, input logic [2:0] ocm);
        chan_cfg[i] = '{sel, filt, pol, PS_NONE, en, 1'h1, ocm};
    endtask : set_ch

    task automatic wait_flag(input int i, input int lim);
        int k;
        k = 0;
        while (channel_event_flag[i] !== 1'h1 && k < lim) begin
            cyc(1);
            k++;
        end
        if (channel_event_flag[i] !== 1'h1) begin
            num_errors++;
            final_report();
        end
    endtask : wait_flag

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_internal();
        check(counter_value, 16'h0000);
        check({update_generate, trigger_flag, channel_event_flag, overcapture_flag,
               channel_irq, compare_reference_signal, compare_output}, 16'h0000);
        counter_run = 1'h1;
        cyc(1);
        start_val = counter_value;
        cyc(10);
        check(counter_value, start_val + 16'h000a);
        count_down = 1'h1;
        cyc(1);
        start_val = counter_value;
        cyc(5);
        check(counter_value, start_val - 16'h0005);
        count_down = 1'h0;
        update_generate_wr = 1'h1;
        cyc(1);
        update_generate_wr = 1'h0;
        check(update_generate, 1'h1);
        cyc(1);
        check(update_generate, 1'h0);
        check(counter_value, 16'h0000);
        $display("test internal done");
    endtask : t_internal

    task automatic t_capture();
        do_reset(2);
        counter_run = 1'h1;
        set_ch(0, CS_OWN_INPUT, FILT_OFF, 1'h0, 1'h1, 3'h0);
        cyc(3);
        pin_req = 2'h1;
        wait_flag(0, 12);
        check(channel_value[0], counter_value - CNT_ONE);
        check(channel_irq[0], 1'h1);
        check(overcapture_flag[0], 1'h0);
        pin_req = 2'h0;
        cyc(4);
        pin_req = 2'h1;
        cyc(8);
        check(overcapture_flag[0], 1'h1);
        value_rd = 2'h1;
        cyc(1);
        value_rd = 2'h0;
        cyc(1);
        check(channel_event_flag[0], 1'h0);
        check(overcapture_flag[0], 1'h1);
        overcapture_clr = 2'h1;
        cyc(1);
        overcapture_clr = 2'h0;
        cyc(1);
        check(overcapture_flag[0], 1'h0);
        chan_cfg[0].input_prescale = 2'h1;
        pin_req = 2'h0;
        cyc(4);
        pin_req = 2'h1;
        cyc(6);
        check(channel_event_flag[0], 1'h0);
        pin_req = 2'h0;
        cyc(4);
        pin_req = 2'h1;
        cyc(6);
        check(channel_event_flag[0], 1'h1);
        $display("test capture done");
    endtask : t_capture

    task automatic t_gate();
        do_reset(2);
        counter_run = 1'h1;
        set_ch(0, CS_OWN_INPUT, FILT_OFF, 1'h0, 1'h0, 3'h0);
        set_ch(1, CS_NEIGH_INPUT, FILT_OFF, 1'h1, 1'h1, 3'h0);
        cyc(3);
        pin_req = 2'h1;
        cyc(10);
        check(channel_event_flag, 2'h0);
        pin_req = 2'h0;
        wait_flag(1, 12);
        check(channel_value[1], counter_value - CNT_ONE);
        check(channel_event_flag[0], 1'h0);
        $display("test gate done");
    endtask : t_gate

    task automatic t_filter();
        do_reset(2);
        counter_run = 1'h1;
        set_ch(0, CS_OWN_INPUT, FILT_N8, 1'h0, 1'h1, 3'h0);
        cyc(2);
        pin_req = 2'h1;
        cyc(5);
        pin_req = 2'h0;
        cyc(1);
        pin_req = 2'h1;
        cyc(5);
        pin_req = 2'h0;
        cyc(20);
        check(channel_event_flag[0], 1'h0);
        pin_req = 2'h1;
        cyc(10);
        check(channel_event_flag[0], 1'h0);
        cyc(1);
        check(channel_event_flag[0], 1'h1);
        $display("test filter done");
    endtask : t_filter

    task automatic t_extclk();
        do_reset(2);
        counter_run = 1'h1;
        slave_mode_select = SMS_EXT_CLK1;
        trigger_select = TS_CH2_EDGE;
        set_ch(1, CS_OWN_INPUT, FILT_OFF, 1'h0, 1'h0, 3'h0);
        cyc(4);
        start_val = counter_value;
        for (int j = 0; j < 2; j++) begin
            repeat (3) begin
                pin_req = 2'h2;
                cyc(4);
                pin_req = 2'h0;
                cyc(4);
            end
            cyc(4);
            check(counter_value, start_val + 16'h0003);
            trigger_select = 3'h7;
        end
        trigger_select = 3'h1;
        itr_req = 4'h2;
        cyc(2);
        itr_req = 4'h0;
        cyc(2);
        check(counter_value, start_val + 16'h0004);
        check(trigger_flag, 1'h1);
        trigger_flag_clr = 1'h1;
        cyc(1);
        trigger_flag_clr = 1'h0;
        cyc(1);
        check(trigger_flag, 1'h0);
        $display("test external clock done");
    endtask : t_extclk

    task automatic t_resetmode();
        do_reset(2);
        counter_run = 1'h1;
        slave_mode_select = SMS_RESET;
        trigger_select = TS_CH1_EDGE;
        set_ch(0, CS_OWN_INPUT, FILT_OFF, 1'h0, 1'h0, 3'h0);
        cyc(30);
        pin_req = 2'h1;
        cyc(8);
        check(counter_value, 16'h0004);
        check(trigger_flag, 1'h1);
        $display("test reset mode done");
    endtask : t_resetmode

    task automatic t_output();
        do_reset(2);
        counter_run = 1'h1;
        set_ch(0, CS_OUTPUT, FILT_OFF, 1'h0, 1'h1, OCM_FORCE_HIGH);
        cyc(3);
        check({compare_reference_signal[0], compare_output[0]}, 2'h3);
        chan_cfg[0].channel_polarity = 1'h1;
        cyc(3);
        check({compare_reference_signal[0], compare_output[0]}, 2'h2);
        chan_cfg[0].output_compare_mode_sel = OCM_FORCE_LOW;
        cyc(3);
        check({compare_reference_signal[0], compare_output[0]}, 2'h1);
        value_wr_data = counter_value + 16'h0014;
        value_wr = 2'h1;
        event_flag_clr = 2'h1;
        cyc(1);
        value_wr = 2'h0;
        event_flag_clr = 2'h0;
        check(channel_value[0], value_wr_data);
        check(channel_event_flag[0], 1'h0);
        cyc(19);
        check(channel_event_flag[0], 1'h0);
        cyc(1);
        check(channel_event_flag[0], 1'h1);
        check({channel_irq[0], compare_reference_signal[0]}, 2'h2);
        event_flag_clr = 2'h1;
        cyc(1);
        event_flag_clr = 2'h0;
        cyc(1);
        check(channel_event_flag[0], 1'h0);
        set_ch(0, CS_OWN_INPUT, FILT_OFF, 1'h0, 1'h1, 3'h0);
        cyc(1);
        start_val = channel_value[0];
        value_wr_data = 16'h1234;
        value_wr = 2'h1;
        cyc(1);
        value_wr = 2'h0;
        cyc(1);
        check(channel_value[0], start_val);
        channel_event_generate = 2'h1;
        start_val = counter_value;
        cyc(1);
        channel_event_generate = 2'h0;
        cyc(1);
        check(channel_event_flag[0], 1'h1);
        check(channel_value[0], start_val);
        $display("test output done");
    endtask : t_output

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        do_reset(12);
        t_internal();
        t_capture();
        t_gate();
        t_filter();
        t_extclk();
        t_resetmode();
        t_output();
        final_report();
    end
endmodule : timer_clock_select_capture_channel_tb

`default_nettype wire
